// [hdl/pph_pkg.sv]
// Constants for the parallel port handshake block.
// Assumes an AXI4-Lite master with 32-bit data and one 10 MHz clock.
package pph_pkg;
  // ==========================================================================
  // Register indices; the byte address is 4 x index
  localparam int unsigned IDX_A_HS_DATA1  = 32'h0000_0000;
  localparam int unsigned IDX_A_HS_DATA2  = 32'h0000_0001;
  localparam int unsigned IDX_A_PLAIN     = 32'h0000_0002;
  localparam int unsigned IDX_B_PLAIN     = 32'h0000_0003;
  localparam int unsigned IDX_PORTC_DIR   = 32'h0000_0007;
  localparam int unsigned IDX_FUNC_SEL    = 32'h0000_0008;
  localparam int unsigned IDX_CTRL_A      = 32'h0000_0009;
  localparam int unsigned IDX_CTRL_B      = 32'h0000_000A;
  localparam int unsigned IDX_STATUS      = 32'h0000_000B;
  localparam int unsigned IDX_B_HS_DATA1  = 32'h0000_000C;
  localparam int unsigned IDX_B_HS_DATA2  = 32'h0000_000D;
  localparam int unsigned IDX_WARNING     = 32'h0000_000E;
  localparam int unsigned IDX_A_DIR       = 32'h0000_0005;
  localparam logic [7:0]  ADDR_A_HS_DATA1 = 8'(IDX_A_HS_DATA1 * 4);
  localparam logic [7:0]  ADDR_A_HS_DATA2 = 8'(IDX_A_HS_DATA2 * 4);
  localparam logic [7:0]  ADDR_A_PLAIN    = 8'(IDX_A_PLAIN * 4);
  localparam logic [7:0]  ADDR_B_PLAIN    = 8'(IDX_B_PLAIN * 4);
  localparam logic [7:0]  ADDR_A_DIR      = 8'(IDX_A_DIR * 4);
  localparam logic [7:0]  ADDR_PORTC_DIR  = 8'(IDX_PORTC_DIR * 4);
  localparam logic [7:0]  ADDR_FUNC_SEL   = 8'(IDX_FUNC_SEL * 4);
  localparam logic [7:0]  ADDR_CTRL_A     = 8'(IDX_CTRL_A * 4);
  localparam logic [7:0]  ADDR_CTRL_B     = 8'(IDX_CTRL_B * 4);
  localparam logic [7:0]  ADDR_STATUS     = 8'(IDX_STATUS * 4);
  localparam logic [7:0]  ADDR_B_HS_DATA1 = 8'(IDX_B_HS_DATA1 * 4);
  localparam logic [7:0]  ADDR_B_HS_DATA2 = 8'(IDX_B_HS_DATA2 * 4);
  localparam logic [7:0]  ADDR_WARNING    = 8'(IDX_WARNING * 4);
  // ==========================================================================
  // Field positions
  localparam int unsigned HS_A_IN    = 0;  // line index: a_in_hs
  localparam int unsigned HS_A_BIDIR = 1;
  localparam int unsigned HS_B_IN    = 2;
  localparam int unsigned HS_B_BIDIR = 3;
  localparam int unsigned IRQ_FLAG_BIT   = 7;
  localparam int unsigned DIR_A_BIDIR_BIT = 5;
  localparam int unsigned DIR_B_BIDIR_BIT = 7;
  localparam int unsigned FSEL_LSB   = 4;  // func select bits 4..7 map to lines 0..3
  localparam int unsigned LE_BIT     = 2;
  localparam int unsigned OUT_LVL_BIT = 4;
  localparam logic [7:0]  RESET_BYTE = 8'h00;
  localparam logic [1:0]  AXI_OKAY   = 2'b00;
  localparam logic [1:0]  AXI_DECERR = 2'b11;
  typedef enum logic [1:0] {
    PPH_OM_INTERLOCK,
    PPH_OM_PULSE,
    PPH_OM_LOW,
    PPH_OM_HIGH
  } pph_omode_t;
endpackage

// [hdl/pph_top.sv]
// Handshake logic of a 24-line parallel port, registers over AXI4-Lite.
// Assumes one 10 MHz clock; addr_strobe and port pins are asynchronous.
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
// Contract
// - Upper port C pins: GPIO or handshake per select
// - Bidir line directions follow port C bits 5,7
// - Active edge on input line sets status
// - Codes 0x falling, 1x rising edge
// - Modes 1,3 set irq flag, assert request
// - Request released when enabled status bits clear
// - Edge on set status sets warning bit
// - Warning clears: data access then warning read
// - Reset clears mode bits, disables handshake
// - Latch enable captures port A on edge
// - Unlatched: reads show live pins, outputs latch
// - Latched: reads show captured pins
// - Further edges only set warning, keep capture
// - Capture released when read clears status
// - Modes 2,3 drive control bit 4 statically
// - Port A line low after data1 read, or data2 read with input status clear
// - Port B line low after data1 write, or data2 write with input status clear
// - Mode 0 returns high on input edge
// - Mode 1 returns high on next strobe step
// - Mode 1 steps on strobe edges A rise, B fall
// - First entry drives default level
// - Output modes only when direction is output
// - Interrupt output low while irq flag set
// - After reset every line is input
module pph_top (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic        addr_strobe_i,
  input  wire logic [7:0]  porta_pins_i,
  output logic [7:0]       porta_pins_o,
  output logic [7:0]       porta_oe_o,
  input  wire logic [3:0]  hs_pins_i,
  output logic [3:0]       hs_pins_o,
  output logic [3:0]       hs_oe_o,
  output logic             irq_n_o,
  output logic             irq_oe_o
);
  import pph_pkg::*;

  // ==========================================================================
  // Synchronisers: 3 stages, change taken when stages 2 and 3 agree
  logic [5:0] sync1_q, sync2_q, sync3_q, stable_q, stable_prev_q;
  logic [7:0] pa1_q, pa2_q, pa3_q, pa_q;
  wire  [5:0] raw_in = {addr_strobe_i, 1'b0, hs_pins_i};
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync1_q       <= 6'h3F;
      sync2_q       <= 6'h3F;
      sync3_q       <= 6'h3F;
      stable_q      <= 6'h3F;
      stable_prev_q <= 6'h3F;
    end else begin
      sync1_q       <= raw_in;
      sync2_q       <= sync1_q;
      sync3_q       <= sync2_q;
      stable_prev_q <= stable_q;
      for (int i = 0; i < 6; i++) begin
        if (sync2_q[i] == sync3_q[i]) begin
          stable_q[i] <= sync3_q[i];
        end
      end
    end
  end
  always_ff @(posedge clk_i) begin
    pa1_q <= porta_pins_i;
    pa2_q <= pa1_q;
    pa3_q <= pa2_q;
    pa_q  <= (pa3_q & ~(pa2_q ^ pa3_q)) | (pa_q & (pa2_q ^ pa3_q));
  end

  // ==========================================================================
  // Registers
  logic [7:0] func_sel_q, portc_dir_q, ctrl_a_q, ctrl_b_q, a_dir_q;
  logic [7:0] a_out_q, b_out_q, a_capture_q;
  logic [3:0] status_q, warning_q, warn_armed_q;
  logic       irq_flag_q;
  logic [3:0] bidir_lvl_q;  // index 0: port A line, 1: port B line

  wire as_rise = stable_q[5] & ~stable_prev_q[5];
  wire as_fall = ~stable_q[5] & stable_prev_q[5];

  function automatic logic active_edge(input logic cur, input logic prev, input logic [1:0] mode);
    active_edge = mode[1] ? (cur & ~prev) : (~cur & prev);
  endfunction

  // Handshake role: function select on and (for bidir) direction input
  logic [3:0] hs_en, hs_is_in;
  logic [1:0] line_mode [4];
  always_comb begin
    line_mode[HS_A_IN]    = ctrl_a_q[1:0];
    line_mode[HS_A_BIDIR] = {ctrl_a_q[3], ctrl_a_q[4]};  // Bit 4 is the mode LSB: it alone sets the static level
    line_mode[HS_B_IN]    = ctrl_b_q[1:0];
    line_mode[HS_B_BIDIR] = {ctrl_b_q[3], ctrl_b_q[4]};
    hs_en    = func_sel_q[FSEL_LSB +: 4];
    hs_is_in = hs_en & ~{portc_dir_q[DIR_B_BIDIR_BIT], 1'b0, portc_dir_q[DIR_A_BIDIR_BIT], 1'b0};
  end

  logic [3:0] edge_ev;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      edge_ev[i] = hs_is_in[i] & active_edge(stable_q[i], stable_prev_q[i], line_mode[i]);
    end
  end

  // ==========================================================================
  // AXI4-Lite slave
  logic        aw_hold_q, w_hold_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  wire do_write = aw_hold_q & w_hold_q & ~s_axi_bvalid_o;
  wire do_read  = s_axi_arvalid_i & s_axi_arready_o;
  wire wr_ok    = do_write & w_strb_q[0];
  wire [7:0] wr_byte = w_data_q[7:0];
  wire [7:0] rd_addr = s_axi_araddr_i;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == ADDR_A_HS_DATA1) || (a == ADDR_A_HS_DATA2) || (a == ADDR_A_PLAIN) ||
             (a == ADDR_B_PLAIN) || (a == ADDR_A_DIR) || (a == ADDR_PORTC_DIR) ||
             (a == ADDR_FUNC_SEL) || (a == ADDR_CTRL_A) || (a == ADDR_CTRL_B) ||
             (a == ADDR_STATUS) || (a == ADDR_B_HS_DATA1) || (a == ADDR_B_HS_DATA2) ||
             (a == ADDR_WARNING);
  endfunction

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      aw_hold_q       <= 1'b0;
      w_hold_q        <= 1'b0;
      aw_addr_q       <= RESET_BYTE;
      w_data_q        <= '0;
      w_strb_q        <= '0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= AXI_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_hold_q       <= 1'b1;
        aw_addr_q       <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_hold_q       <= 1'b1;
        w_data_q       <= s_axi_wdata_i;
        w_strb_q       <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= mapped(aw_addr_q) ? AXI_OKAY : AXI_DECERR;
        aw_hold_q      <= 1'b0;
        w_hold_q       <= 1'b0;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o  <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
    end
  end

  // Port A read value: captured pins while latched, else live
  wire       a_latched = ctrl_a_q[LE_BIT] & status_q[HS_A_IN];
  wire [7:0] a_in_val  = a_latched ? a_capture_q : pa_q;
  wire [7:0] a_read    = (a_dir_q & a_out_q) | (~a_dir_q & a_in_val);
  logic [7:0] rd_byte;
  always_comb begin
    if (rd_addr == ADDR_A_HS_DATA1 || rd_addr == ADDR_A_HS_DATA2 || rd_addr == ADDR_A_PLAIN) begin
      rd_byte = a_read;
    end else if (rd_addr == ADDR_B_PLAIN || rd_addr == ADDR_B_HS_DATA1 || rd_addr == ADDR_B_HS_DATA2) begin
      rd_byte = b_out_q;
    end else if (rd_addr == ADDR_A_DIR) begin
      rd_byte = a_dir_q;
    end else if (rd_addr == ADDR_PORTC_DIR) begin
      rd_byte = portc_dir_q;
    end else if (rd_addr == ADDR_FUNC_SEL) begin
      rd_byte = func_sel_q;
    end else if (rd_addr == ADDR_CTRL_A) begin
      rd_byte = ctrl_a_q;
    end else if (rd_addr == ADDR_CTRL_B) begin
      rd_byte = ctrl_b_q;
    end else if (rd_addr == ADDR_STATUS) begin
      rd_byte = {irq_flag_q, 3'b000, status_q};
    end else if (rd_addr == ADDR_WARNING) begin
      rd_byte = {4'h0, warning_q};
    end else begin
      rd_byte = RESET_BYTE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= '0;
      s_axi_rresp_o   <= AXI_OKAY;
    end else if (do_read) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rdata_o   <= {24'h00_0000, rd_byte};
      s_axi_rresp_o   <= mapped(rd_addr) ? AXI_OKAY : AXI_DECERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o  <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  // Access events that clear status or warning
  wire rd_a1 = do_read & (rd_addr == ADDR_A_HS_DATA1);
  wire rd_a2 = do_read & (rd_addr == ADDR_A_HS_DATA2);
  wire wr_b1 = wr_ok & (aw_addr_q == ADDR_B_HS_DATA1);
  wire wr_b2 = wr_ok & (aw_addr_q == ADDR_B_HS_DATA2);
  wire rd_warn = do_read & (rd_addr == ADDR_WARNING);
  wire [3:0] clr_stat = {wr_b2, wr_b1, rd_a2, rd_a1};

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      func_sel_q  <= RESET_BYTE;
      portc_dir_q <= RESET_BYTE;
      ctrl_a_q    <= RESET_BYTE;
      ctrl_b_q    <= RESET_BYTE;
      a_dir_q     <= RESET_BYTE;
    end else if (wr_ok) begin
      if (aw_addr_q == ADDR_FUNC_SEL) begin
        func_sel_q <= wr_byte;
      end else if (aw_addr_q == ADDR_PORTC_DIR) begin
        portc_dir_q <= wr_byte;
      end else if (aw_addr_q == ADDR_CTRL_A) begin
        ctrl_a_q <= {3'b000, wr_byte[4:0]};
      end else if (aw_addr_q == ADDR_CTRL_B) begin
        ctrl_b_q <= {3'b000, wr_byte[4:3], 1'b0, wr_byte[1:0]};
      end else if (aw_addr_q == ADDR_A_DIR) begin
        a_dir_q <= wr_byte;
      end
    end
  end

  // Data latches keep contents across reset
  always_ff @(posedge clk_i) begin
    if (wr_ok && aw_addr_q == ADDR_A_PLAIN) begin
      a_out_q <= wr_byte;
    end
    if (wr_ok && (aw_addr_q == ADDR_B_PLAIN || aw_addr_q == ADDR_B_HS_DATA1)) begin
      b_out_q <= wr_byte;
    end
    if (edge_ev[HS_A_IN] && ctrl_a_q[LE_BIT] && (!status_q[HS_A_IN] || clr_stat[HS_A_IN])) begin
      a_capture_q <= pa_q;
    end
  end

  // ==========================================================================
  // Status, warning, irq flag; set wins over clear
  wire [3:0] irq_en = {line_mode[HS_B_BIDIR][0], line_mode[HS_B_IN][0],
                       line_mode[HS_A_BIDIR][0], line_mode[HS_A_IN][0]} & hs_is_in;
  wire [3:0] status_d = (status_q & ~clr_stat) | edge_ev;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      status_q     <= '0;
      warning_q    <= '0;
      warn_armed_q <= '0;
      irq_flag_q   <= 1'b0;
      irq_n_o      <= 1'b1;
      irq_oe_o     <= 1'b0;
    end else begin
      status_q <= status_d;
      for (int i = 0; i < 4; i++) begin
        if (edge_ev[i] && status_q[i]) begin
          warning_q[i]    <= 1'b1;
          warn_armed_q[i] <= 1'b0;
        end else if (rd_warn && warn_armed_q[i]) begin
          warning_q[i]    <= 1'b0;
          warn_armed_q[i] <= 1'b0;
        end else if (clr_stat[i]) begin
          warn_armed_q[i] <= 1'b1;
        end
      end
      irq_flag_q <= |(status_d & irq_en);
      irq_n_o    <= ~(|(status_d & irq_en));
      irq_oe_o   <= |(status_d & irq_en);
    end
  end

  // ==========================================================================
  // Bidirectional handshake outputs
  logic [1:0] pend_low_q;  // mode 1: strobe step pending
  wire [1:0] trig_low = {wr_b1 | (wr_b2 & ~status_q[HS_B_IN]),
                         rd_a1 | (rd_a2 & ~status_q[HS_A_IN])};
  wire [1:0] step_as  = {as_fall, as_rise};
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bidir_lvl_q <= 4'hF;
      pend_low_q  <= '0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        case (pph_omode_t'(line_mode[2*p+1]))
          PPH_OM_INTERLOCK: begin
            pend_low_q[p] <= 1'b0;
            if (trig_low[p]) begin
              bidir_lvl_q[p] <= 1'b0;
            end else if (hs_en[2*p] && active_edge(stable_q[2*p], stable_prev_q[2*p], line_mode[2*p])) begin
              bidir_lvl_q[p] <= 1'b1;
            end
          end
          PPH_OM_PULSE: begin
            if (trig_low[p]) begin
              pend_low_q[p] <= 1'b1;
            end
            if (step_as[p]) begin
              if (!bidir_lvl_q[p]) begin
                bidir_lvl_q[p] <= 1'b1;
              end else if (pend_low_q[p]) begin
                bidir_lvl_q[p] <= 1'b0;
                pend_low_q[p]  <= 1'b0;
              end
            end
          end
          default: begin
            pend_low_q[p]  <= 1'b0;
            bidir_lvl_q[p] <= (2*p+1 == HS_A_BIDIR) ? ctrl_a_q[OUT_LVL_BIT] : ctrl_b_q[OUT_LVL_BIT];
          end
        endcase
      end
    end
  end

  // Pins: handshake lines drive only bidir lines set to output
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hs_pins_o    <= '0;
      hs_oe_o      <= '0;
      porta_pins_o <= '0;
      porta_oe_o   <= '0;
    end else begin
      hs_pins_o    <= {bidir_lvl_q[1], 1'b0, bidir_lvl_q[0], 1'b0};
      hs_oe_o      <= {hs_en[HS_B_BIDIR] & portc_dir_q[DIR_B_BIDIR_BIT], 1'b0,
                       hs_en[HS_A_BIDIR] & portc_dir_q[DIR_A_BIDIR_BIT], 1'b0};
      porta_pins_o <= a_out_q;
      porta_oe_o   <= a_dir_q;
    end
  end

  // ==========================================================================
  // Assertions
  AST_IRQ_FOLLOWS_FLAG: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    irq_n_o == !irq_flag_q) else $error("irq pin disagrees with flag");
  AST_STATUS_SET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    edge_ev[HS_A_IN] |=> status_q[HS_A_IN]) else $error("status not set on edge");
  AST_WARN_SET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    edge_ev[HS_B_IN] && status_q[HS_B_IN] |=> warning_q[HS_B_IN]) else $error("warning missed");
  AST_CAPTURE_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    status_q[HS_A_IN] && $past(status_q[HS_A_IN]) && !$past(clr_stat[HS_A_IN]) |-> $stable(a_capture_q))
    else $error("capture overwritten");
  AST_A_LOW_AFTER_READ: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_a1 && ctrl_a_q[4:3] == 2'b00 |=> !bidir_lvl_q[0]) else $error("A line not low after read");
  AST_B_LOW_AFTER_WRITE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_b1 && ctrl_b_q[4:3] == 2'b00 |=> !bidir_lvl_q[1]) else $error("B line not low after write");
  AST_STATIC_LEVEL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ctrl_a_q[3] && $past(ctrl_a_q[3]) && $stable(ctrl_a_q[4]) && $past(rst_n_i) |-> bidir_lvl_q[0] == ctrl_a_q[4])
    else $error("static level wrong");
  AST_NO_IRQ_MODE0: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (irq_en == 4'h0) ##1 (irq_en == 4'h0) |-> irq_n_o) else $error("irq without enable");
  AST_PULSE_RETURNS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ctrl_a_q[4:3] == 2'b10 && !bidir_lvl_q[0] && as_rise |=> bidir_lvl_q[0])
    else $error("pulse did not return high");
  AST_RESET_INPUTS: assert property (@(posedge clk_i)
    rst_n_i && !$past(rst_n_i) |-> hs_oe_o == 4'h0 && porta_oe_o == 8'h00) else $error("line driven after reset");
  COV_IRQ: cover property (@(posedge clk_i) disable iff (!rst_n_i) $fell(irq_n_o));
  COV_WARN: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(warning_q[HS_A_IN]));
  COV_CAPTURE: cover property (@(posedge clk_i) disable iff (!rst_n_i) a_latched && rd_a1);
endmodule

// [bench/pph_periph.sv]
// Peripheral on the port A data pins and the two input handshake lines.
// Assumes the bench resolves the shared bidir lines and calls its tasks.
`timescale 1ns/1ns
module pph_periph (
  input  wire logic       clk_i,
  input  wire logic       auto_i,
  input  wire logic [1:0] bidir_i,
  output logic      [1:0] in_o,
  output logic      [7:0] porta_o
);
  // ==========================================================================
  // Strobes idle high, so reset sees no edge
  initial begin
    in_o = 2'b11;
    porta_o = 8'h00;
  end
  task automatic put(input logic [7:0] d);
    @(posedge clk_i);
    porta_o <= d;
    // Let the pins pass the synchroniser before anyone reads them
    repeat (6) @(posedge clk_i);
  endtask
  task automatic lvl(input int p, input logic v);
    @(posedge clk_i);
    in_o[p] <= v;
    repeat (8) @(posedge clk_i);
  endtask
  // Low pulse: one falling and one rising edge, so any mode sees one active edge
  task automatic strobe(input int p);
    lvl(p, 1'b0);
    lvl(p, 1'b1);
  endtask
  // ==========================================================================
  // Slow interlocked reply to a low bidir line
  always begin
    @(negedge bidir_i[0]);
    if (auto_i) begin
      repeat (20) @(posedge clk_i);
      strobe(0);
    end
  end
  always begin
    @(negedge bidir_i[1]);
    if (auto_i) begin
      repeat (20) @(posedge clk_i);
      strobe(1);
    end
  end
endmodule

// [bench/tb_top.sv]
// Self-checking bench for the handshake block over AXI4-Lite.
// Assumes pull-ups on the bidir lines when the block does not drive them.
`timescale 1ns/1ns
module tb_top;
  import pph_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [7:0]  rd;
  logic [31:0] wdata = 32'h0000_0000;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, auto = 1'b0;
  logic [3:0]  wstrb = 4'h1;
  logic [2:0]  as_cnt = 3'h0;
  logic        awready, wready, bvalid, arready, rvalid, irq_n, irq_oe;
  logic [1:0]  bresp, rresp, last_rresp, pin_in;
  logic [31:0] rdata;
  logic [7:0]  pa_i, pa_o, pa_oe;
  logic [3:0]  hs_o, hs_oe;
  wire  [3:0]  hs_i = {hs_oe[3] ? hs_o[3] : 1'b1, pin_in[1], hs_oe[1] ? hs_o[1] : 1'b1, pin_in[0]};
  int          failures = 0;
  int          n_checks = 0;
  int          lo = 0;
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) as_cnt <= as_cnt + 3'h1;
  pph_top DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .addr_strobe_i(as_cnt[2]),
    .porta_pins_i(pa_i), .porta_pins_o(pa_o), .porta_oe_o(pa_oe), .hs_pins_i(hs_i), .hs_pins_o(hs_o),
    .hs_oe_o(hs_oe), .irq_n_o(irq_n), .irq_oe_o(irq_oe));
  pph_periph P (.clk_i(clk_i), .auto_i(auto), .bidir_i({hs_i[3], hs_i[1]}), .in_o(pin_in), .porta_o(pa_i));
  // ==========================================================================
  // Bus and compare tasks
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    logic aw, w;
    n = 0;
    aw = 1'b1;
    w = 1'b1;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end while (!bvalid && n < 200);
    bready <= 1'b0;
    if (n >= 200) failures++;
  endtask
  task automatic rd_(input logic [7:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 200);
    d = rdata[7:0];
    last_rresp = rresp;
    rready <= 1'b0;
    if (n >= 200) failures++;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm);
    rd_(a, rd);
    chk(nm, e, rd);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================================================
  // Tests
  initial begin
    repeat (30000) @(posedge clk_i);
    failures++;
    wrap_up();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rc(ADDR_CTRL_A, 8'h00, "ctrl_a");
    rc(ADDR_CTRL_B, 8'h00, "ctrl_b");
    rc(ADDR_PORTC_DIR, 8'h00, "portc_dir");
    rc(ADDR_FUNC_SEL, 8'h00, "func_sel");
    chk("hs_oe", 8'h00, {4'h0, hs_oe});
    rc(8'hF0, 8'h00, "unmapped");
    chk("rresp", {6'h00, AXI_DECERR}, {6'h00, last_rresp});
    wstrb <= 4'h0;
    wr(ADDR_CTRL_B, 8'h1B);
    wstrb <= 4'h1;
    rc(ADDR_CTRL_B, 8'h00, "strb_off");
    P.strobe(0);
    rc(ADDR_STATUS, 8'h00, "status_gpio");
    $display("test reset done");
    wr(ADDR_FUNC_SEL, 8'hF0);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_CTRL_A, 8'(m));
      P.lvl(0, 1'b0);
      rc(ADDR_STATUS, (m < 2) ? {m[0], 7'h01} : 8'h00, "status_fall");
      P.lvl(0, 1'b1);
      rc(ADDR_STATUS, {m[0], 7'h01}, "status_rise");
      chk("irq_n", {7'h00, ~m[0]}, {7'h00, irq_n});
      chk("irq_oe", {7'h00, m[0]}, {7'h00, irq_oe});
      rc(ADDR_WARNING, 8'h00, "warn_one_edge");
      rd_(ADDR_A_HS_DATA1, rd);
      rc(ADDR_STATUS, 8'h00, "status_clr");
      chk("irq_rel", 8'h01, {7'h00, irq_n});
    end
    $display("test input modes done");
    wr(ADDR_CTRL_A, 8'h00);
    P.strobe(0);
    P.strobe(0);
    rc(ADDR_WARNING, 8'h01, "warn_set");
    rc(ADDR_WARNING, 8'h01, "warn_kept");
    rd_(ADDR_A_HS_DATA1, rd);
    rc(ADDR_WARNING, 8'h01, "warn_last");
    rc(ADDR_WARNING, 8'h00, "warn_clr");
    $display("test warning done");
    wr(ADDR_A_PLAIN, 8'h30);
    wr(ADDR_A_DIR, 8'hF0);
    cyc(1);
    chk("pa_oe", 8'hF0, pa_oe);
    chk("pa_out", 8'h30, pa_o);
    wr(ADDR_CTRL_A, 8'h04);
    P.put(8'h5A);
    rc(ADDR_A_PLAIN, 8'h3A, "live");
    P.strobe(0);
    P.put(8'hC3);
    rc(ADDR_A_HS_DATA2, 8'h3A, "held");
    P.strobe(0);
    P.put(8'h11);
    rc(ADDR_A_PLAIN, 8'h3A, "no_relatch");
    rc(ADDR_WARNING, 8'h01, "relatch_warn");
    rc(ADDR_A_HS_DATA1, 8'h3A, "release_rd");
    rc(ADDR_A_PLAIN, 8'h31, "released");
    $display("test latch done");
    wr(ADDR_CTRL_A, 8'h08);
    chk("a_oe_in_dir", 8'h00, {7'h00, hs_oe[1]});
    wr(ADDR_PORTC_DIR, 8'hA0);
    cyc(1);
    chk("hs_oe_out", 8'h0A, {4'h0, hs_oe});
    chk("hs_level", 8'h08, {4'h0, hs_o & 4'hA});
    wr(ADDR_CTRL_A, 8'h18);
    cyc(2);
    chk("hs_high", 8'h0A, {4'h0, hs_o & 4'hA});
    wr(ADDR_CTRL_A, 8'h00);
    auto <= 1'b1;
    rd_(ADDR_A_HS_DATA1, rd);
    cyc(2);
    chk("a_low", 8'h00, {7'h00, hs_o[1]});
    cyc(40);
    chk("a_back", 8'h01, {7'h00, hs_o[1]});
    rd_(ADDR_A_HS_DATA2, rd);
    cyc(2);
    chk("a_no_low", 8'h01, {7'h00, hs_o[1]});
    wr(ADDR_B_HS_DATA1, 8'h00);
    cyc(2);
    chk("b_low", 8'h00, {7'h00, hs_o[3]});
    cyc(40);
    chk("b_back", 8'h01, {7'h00, hs_o[3]});
    wr(ADDR_B_HS_DATA2, 8'h00);
    cyc(2);
    chk("b_no_low", 8'h01, {7'h00, hs_o[3]});
    auto <= 1'b0;
    $display("test output done");
    wr(ADDR_CTRL_A, 8'h10);
    rd_(ADDR_A_HS_DATA1, rd);
    lo = 0;
    while (hs_o[1] && lo < 40) begin
      cyc(1);
      lo++;
    end
    lo = 0;
    while (!hs_o[1] && lo < 40) begin
      cyc(1);
      lo++;
    end
    // Strobe from as_cnt[2] has a period of 8 clocks
    chk("pulse_len", 8'h08, 8'(lo));
    $display("test pulse done");
    rst_n_i <= 1'b0;
    cyc(3);
    rst_n_i <= 1'b1;
    rc(ADDR_CTRL_A, 8'h00, "ctrl_a_rst");
    rc(ADDR_PORTC_DIR, 8'h00, "portc_dir_rst");
    chk("hs_oe_rst", 8'h00, {4'h0, hs_oe});
    $display("test reset again done");
    wrap_up();
  end
endmodule
